// [include/gab_regs.svh]
// register offsets, field positions and reset values of the aperture base
`ifndef GAB_REGS_SVH
`define GAB_REGS_SVH

`define GAB_BASE_OFS   8'h10
`define GAB_BASE_RST   32'h0000_0008
`define GAB_HI_MSB     31
`define GAB_HI_LSB     28
`define GAB_MID_MSB    27
`define GAB_MID_LSB    22
`define GAB_LOW_MSB    21
`define GAB_LOW_LSB    4
`define GAB_PREF_BIT   3
`define GAB_TYPE_MSB   2
`define GAB_TYPE_LSB   1
`define GAB_MSPACE_BIT 0
`define GAB_HI_RST     4'h0
`define GAB_MID_RST    6'h00
`define GAB_ENABLE_BIT 9

`endif

// [include/gab_pkg.sv]
// types and decode helpers of the graphics aperture base block
package gab_pkg;

   // configuration access from the host
   typedef struct packed {
      logic        req;
      logic        we;
      logic [7:0]  addr;
      logic [3:0]  be;
      logic [31:0] wdata;
   } gab_cfg_req_t;

   // processor memory access presented for decode
   typedef struct packed {
      logic        req;
      logic        we;
      logic [31:0] addr;
      logic [3:0]  be;
      logic [31:0] data;
   } gab_cpu_req_t;

   // routing verdict of one processor access
   typedef enum logic [3:0] {
      GAB_RT_IDLE  = 4'h1,
      GAB_RT_PASS  = 4'h2,
      GAB_RT_XLATE = 4'h4,
      GAB_RT_BLOCK = 4'h8
   } gab_route_t;

   typedef struct packed {
      gab_route_t  route;
      logic        we;
      logic [31:0] addr;
      logic [3:0]  be;
   } gab_cpu_rsp_t;

   typedef struct packed {
      logic [3:0]   base_hi;
      logic [5:0]   base_mid;
      logic         ack;
      logic [31:0]  rdata;
      gab_cpu_rsp_t rsp;
   } gab_state_t;

   typedef struct packed {
      logic        valid;
      logic [29:0] addr;
      logic [3:0]  be;
      logic [31:0] data;
      logic        o_valid;
      logic [29:0] o_addr;
      logic [3:0]  o_be;
      logic [31:0] o_data;
   } gab_merge_t;

   // aperture hit: upper nibble exact, middle bits only where unmasked
   function automatic logic gab_hit(input logic [31:0] addr,
                                    input logic [3:0]  hi,
                                    input logic [5:0]  mid,
                                    input logic [5:0]  mask);
      gab_hit = (addr[31:28] == hi) && (((addr[27:22] ^ mid) & ~mask) == 6'h00);
   endfunction : gab_hit

   // read image of the base register
   function automatic logic [31:0] gab_image(input logic [3:0] hi,
                                             input logic [5:0] mid,
                                             input logic [5:0] mask);
      gab_image = {hi, mid & ~mask, 18'h00000, 1'b1, 2'b00, 1'b0};
   endfunction : gab_image

endpackage : gab_pkg

// [hdl/gab_wmerge.sv]
// one-entry write combiner for processor writes into the aperture
`timescale 1ns/1ps
module gab_wmerge
(
   input  wire logic        core_clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        wr_valid_in,
   input  wire logic [29:0] wr_addr_in,
   input  wire logic [3:0]  wr_be_in,
   input  wire logic [31:0] wr_data_in,
   output logic             out_valid_out,
   output logic [29:0]      out_addr_out,
   output logic [3:0]       out_be_out,
   output logic [31:0]      out_data_out
);
   import gab_pkg::*;

   gab_merge_t st;
   gab_merge_t next_st;

   // merge same-dword writes, emit on a new dword or an idle cycle
   always_comb
   begin
      next_st = st;
      next_st.o_valid = 1'b0;
      if (wr_valid_in)
      begin
         if (st.valid && (st.addr == wr_addr_in))
         begin
            // later bytes overwrite earlier ones, so merging is lossless
            for (int i = 0; i < 4; i++)
            begin
               if (wr_be_in[i])
               begin
                  next_st.data[8*i +: 8] = wr_data_in[8*i +: 8];
               end
            end
            next_st.be = st.be | wr_be_in;
         end
         else
         begin
            next_st.o_valid = st.valid;
            next_st.o_addr  = st.addr;
            next_st.o_be    = st.be;
            next_st.o_data  = st.data;
            next_st.valid   = 1'b1;
            next_st.addr    = wr_addr_in;
            next_st.be      = wr_be_in;
            next_st.data    = wr_data_in;
         end
      end
      else if (st.valid)
      begin
         next_st.o_valid = 1'b1;
         next_st.o_addr  = st.addr;
         next_st.o_be    = st.be;
         next_st.o_data  = st.data;
         next_st.valid   = 1'b0;
      end
   end

   // state register
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign out_valid_out = st.o_valid;
   assign out_addr_out  = st.o_addr;
   assign out_be_out    = st.o_be;
   assign out_data_out  = st.o_data;

endmodule : gab_wmerge

// [hdl/gab_top.sv]
// graphics aperture base register with aperture decode and write combining
// Operation
// - 32-bit register at 0x10, resets 0x00000008
// - bits 31:28 writable, matching accesses translated
// - bits 27:22 writable unless size-masked, then zero
// - bits 21:4 read zero, 4 MB minimum
// - bit 3 reads one, prefetchable
// - bits 2:1 read 00, anywhere 32-bit
// - bit 0 reads zero, memory range
// - aperture reads side-effect free, all bytes when translated; blocked reads keep their own byte enables
// - aperture writes may merge without error
// - chip config bit 9 clear blocks aperture accesses
`timescale 1ns/1ps
`include "gab_regs.svh"
module gab_top
(
   input  wire logic                 core_clk_in,
   input  wire logic                 rst_n_in,
   input  wire gab_pkg::gab_cfg_req_t cfg_in,
   output logic                      cfg_ack_out,
   output logic [31:0]               cfg_rdata_out,
   input  wire logic [5:0]           aperture_size_mask_in,
   input  wire logic [31:0]          hub_chip_configuration_in,
   input  wire gab_pkg::gab_cpu_req_t cpu_in,
   output gab_pkg::gab_cpu_rsp_t     cpu_rsp_out,
   output logic                      mwr_valid_out,
   output logic [31:0]               mwr_addr_out,
   output logic [3:0]                mwr_be_out,
   output logic [31:0]               mwr_data_out
);
   import gab_pkg::*;

   gab_state_t  st;
   gab_state_t  next_st;
   logic        cfg_hit;
   logic        ap_hit;
   logic        ap_en;
   logic        ap_wr;
   logic [29:0] mwr_dw;

   // decode of the config offset and of the processor address
   assign cfg_hit = cfg_in.req && (cfg_in.addr == `GAB_BASE_OFS);
   assign ap_hit = cpu_in.req &&
                   gab_hit(cpu_in.addr, st.base_hi, st.base_mid, aperture_size_mask_in);
   assign ap_en  = hub_chip_configuration_in[`GAB_ENABLE_BIT];
   // only enabled aperture writes enter the combiner
   assign ap_wr  = ap_hit && ap_en && cpu_in.we;

   // next-state logic for the register and the access verdict
   always_comb
   begin
      next_st = st;
      // every config access answered next cycle
      next_st.ack   = cfg_in.req;
      next_st.rdata = 32'h0000_0000;
      if (cfg_hit && cfg_in.we)
      begin
         // upper base nibble in byte lane 3
         if (cfg_in.be[3])
         begin
            next_st.base_hi = cfg_in.wdata[`GAB_HI_MSB:`GAB_HI_LSB];
         end
         // masked middle bits drop the written value
         if (cfg_in.be[3])
         begin
            next_st.base_mid[5:2] = cfg_in.wdata[27:24] & ~aperture_size_mask_in[5:2];
         end
         if (cfg_in.be[2])
         begin
            next_st.base_mid[1:0] = cfg_in.wdata[23:22] & ~aperture_size_mask_in[1:0];
         end
      end
      else if (cfg_hit)
      begin
         // fixed bits come from the image
         next_st.rdata = gab_image(st.base_hi, st.base_mid, aperture_size_mask_in);
      end

      // verdict for the processor access
      next_st.rsp.route = GAB_RT_IDLE;
      next_st.rsp.we    = cpu_in.we;
      next_st.rsp.addr  = cpu_in.addr;
      next_st.rsp.be    = cpu_in.be;
      if (cpu_in.req)
      begin
         if (ap_hit && !ap_en)
         begin
            // refuse until software has set up
            next_st.rsp.route = GAB_RT_BLOCK;
         end
         else if (ap_hit)
         begin
            next_st.rsp.route = GAB_RT_XLATE;
            if (!cpu_in.we)
            begin
               next_st.rsp.be = 4'hf;
            end
         end
         else
         begin
            next_st.rsp.route = GAB_RT_PASS;
         end
      end
   end

   // state register; mask changes later still hide bits on read
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         st          <= '0;
         st.base_hi  <= `GAB_HI_RST;
         st.base_mid <= `GAB_MID_RST;
         st.rsp.route <= GAB_RT_IDLE;
      end
      else
      begin
         st <= next_st;
      end
   end

   gab_wmerge u_wmerge
   (
      .core_clk_in   (core_clk_in),
      .rst_n_in      (rst_n_in),
      .wr_valid_in   (ap_wr),
      .wr_addr_in    (cpu_in.addr[31:2]),
      .wr_be_in      (cpu_in.be),
      .wr_data_in    (cpu_in.data),
      .out_valid_out (mwr_valid_out),
      .out_addr_out  (mwr_dw),
      .out_be_out    (mwr_be_out),
      .out_data_out  (mwr_data_out)
   );

   assign mwr_addr_out  = {mwr_dw, 2'b00};
   assign cfg_ack_out   = st.ack;
   assign cfg_rdata_out = st.rdata;
   assign cpu_rsp_out   = st.rsp;

   // checks on the register image and the verdicts
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!rst_n_in);

   sequence rd_base;
      cfg_hit && !cfg_in.we;
   endsequence

   AST_CFG_ACK: assert property (cfg_in.req |=> cfg_ack_out)
      else $error("config access not answered");

   AST_LOW_ZERO: assert property (rd_base |=> cfg_rdata_out[21:4] == 18'h00000)
      else $error("low base bits not zero");

   AST_PREF_ONE: assert property (rd_base |=> cfg_rdata_out[3])
      else $error("prefetchable bit not one");

   AST_TYPE_ZERO: assert property (rd_base |=> cfg_rdata_out[2:1] == 2'b00)
      else $error("type bits not zero");

   AST_MSPACE_ZERO: assert property (rd_base |=> !cfg_rdata_out[0])
      else $error("memory space bit not zero");

   AST_MID_MASKED: assert property (rd_base |=>
      (cfg_rdata_out[27:22] & $past(aperture_size_mask_in)) == 6'h00)
      else $error("masked base bit reads one");

   // write, one cycle with no write, then a read: the read shows the written nibble
   AST_HI_WRITE: assert property (cfg_hit && cfg_in.we && cfg_in.be[3] ##1
      !(cfg_hit && cfg_in.we) ##1 rd_base |=>
      cfg_rdata_out[31:28] == $past(cfg_in.wdata[31:28], 3))
      else $error("upper base bits not stored");

   AST_BLOCKED: assert property (ap_hit && !ap_en |=> cpu_rsp_out.route == GAB_RT_BLOCK)
      else $error("aperture access not blocked");

   AST_XLATE_RD: assert property (ap_hit && ap_en && !cpu_in.we |=>
      cpu_rsp_out.route == GAB_RT_XLATE && cpu_rsp_out.be == 4'hf)
      else $error("aperture read not full width");

   AST_MISS: assert property (cpu_in.req && !ap_hit |=> cpu_rsp_out.route == GAB_RT_PASS)
      else $error("miss routed to aperture");

   AST_FLUSH: assert property (ap_wr ##1 !ap_wr |=> mwr_valid_out && mwr_be_out != 4'h0)
      else $error("combined write not emitted");

   COV_XLATE: cover property (cpu_rsp_out.route == GAB_RT_XLATE);
   COV_BLOCK: cover property (cpu_rsp_out.route == GAB_RT_BLOCK);
   COV_MERGE: cover property (ap_wr ##1 ap_wr && cpu_in.addr[31:2] == $past(cpu_in.addr[31:2]));

endmodule : gab_top

// [tb/gab_host_model.sv]
// host configuration software model issuing config cycles
`timescale 1ns/1ps
module gab_host_model
(
   input  wire logic             core_clk_in,
   input  wire logic             cfg_ack_in,
   input  wire logic [31:0]      cfg_rdata_in,
   output gab_pkg::gab_cfg_req_t cfg_out,
   output logic [5:0]            size_mask_out
);
   import gab_pkg::*;

   // bus idle at time zero
   initial
   begin
      cfg_out = '0;
      size_mask_out = 6'h00;
   end

   task automatic set_size(input logic [5:0] m);
      @(posedge core_clk_in);
      #1 size_mask_out = m;
   endtask : set_size

   // one cycle held until the answer, then lines inverted so stale data never matches
   task automatic cfg_cycle(input logic we, input logic [7:0] a, input logic [3:0] be,
                            input logic [31:0] wd, output logic [31:0] rd, output logic ok);
      int i;
      ok = 1'b0;
      cfg_out = '{req: 1'b1, we: we, addr: a, be: be, wdata: wd};
      for (i = 0; i < 4 && !ok; i++)
      begin
         @(posedge core_clk_in);
         #1 ok = (cfg_ack_in === 1'b1);
      end
      rd = cfg_rdata_in;
      cfg_out = '{req: 1'b0, we: 1'b0, addr: ~a, be: ~be, wdata: ~wd};
      // one idle edge, so a following call never drives the bus twice in one step
      @(posedge core_clk_in);
      #1;
   endtask : cfg_cycle
endmodule : gab_host_model

// [tb/tb.sv]
// self-checking bench for the aperture base register and decode
`timescale 1ns/1ps
module tb;
   import gab_pkg::*;
   logic         core_clk_in = 1'b0;
   logic         rst_n_in    = 1'b0;
   gab_cfg_req_t cfg_bus;
   logic         cfg_ack;
   logic [31:0]  cfg_rdata, hcfg = 32'hffff_ffff, rd, mwr_addr, mwr_data;
   logic [5:0]   mask;
   gab_cpu_req_t cpu = '0;
   gab_cpu_rsp_t rsp;
   logic         mwr_valid, ok;
   logic [3:0]   mwr_be;
   int           n_fail = 0, total_checks = 0, k;
   // decode table: mask, enable, we, addr, be, route, be seen
   logic [5:0]   t_m [6] = '{6'h00, 6'h00, 6'h01, 6'h01, 6'h00, 6'h00};
   logic         t_en[6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
   logic         t_we[6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
   logic [31:0]  t_a [6] = '{32'h2000_1234, 32'h2040_0000, 32'h2040_0000,
                             32'h3000_0000, 32'h2000_0000, 32'h2000_0010};
   logic [3:0]   t_be[6] = '{4'h1, 4'h2, 4'h2, 4'h3, 4'h4, 4'hf};
   gab_route_t   t_rt[6] = '{GAB_RT_XLATE, GAB_RT_PASS, GAB_RT_XLATE,
                             GAB_RT_PASS, GAB_RT_BLOCK, GAB_RT_BLOCK};
   logic [3:0]   t_rb[6] = '{4'hf, 4'h2, 4'hf, 4'h3, 4'h4, 4'hf};

   // free-running 100 MHz clock
   always #5 core_clk_in = ~core_clk_in;

   gab_top i_gab_top (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .cfg_in(cfg_bus),
      .cfg_ack_out(cfg_ack), .cfg_rdata_out(cfg_rdata), .aperture_size_mask_in(mask),
      .hub_chip_configuration_in(hcfg), .cpu_in(cpu), .cpu_rsp_out(rsp),
      .mwr_valid_out(mwr_valid), .mwr_addr_out(mwr_addr), .mwr_be_out(mwr_be),
      .mwr_data_out(mwr_data));

   gab_host_model i_gab_host_model (.core_clk_in(core_clk_in), .cfg_ack_in(cfg_ack),
      .cfg_rdata_in(cfg_rdata), .cfg_out(cfg_bus), .size_mask_out(mask));

   task automatic give_verdict;
      $display("checks %0d, mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : give_verdict

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : chk

   // config access; a missing answer ends the run
   task automatic cfg(input logic we, input logic [7:0] a, input logic [3:0] be,
                      input logic [31:0] wd);
      i_gab_host_model.cfg_cycle(we, a, be, wd, rd, ok);
      if (!ok)
      begin
         n_fail++;
         give_verdict();
      end
   endtask : cfg

   // one processor access, entered just after an edge
   task automatic cpu_go(input logic we, input logic [31:0] a, input logic [3:0] be,
                         input logic [31:0] d);
      cpu = '{req: 1'b1, we: we, addr: a, be: be, data: d};
      @(posedge core_clk_in);
      #1;
   endtask : cpu_go

   initial
   begin
      repeat (5) @(posedge core_clk_in);
      #1 rst_n_in = 1'b1;
      cfg(1'b0, 8'h10, 4'h0, 32'h0);
      chk(rd, 32'h0000_0008); // reset image
      i_gab_host_model.set_size(6'h00);
      cfg(1'b1, 8'h10, 4'hf, 32'hffff_ffff);
      chk(rd, 32'h0000_0000); // write answers with no data
      cfg(1'b0, 8'h10, 4'h1, 32'h0);
      chk(rd, 32'hffc0_0008); // writable fields
      i_gab_host_model.set_size(6'h0f);
      cfg(1'b1, 8'h10, 4'hf, 32'hffff_ffff);
      cfg(1'b0, 8'h10, 4'hf, 32'h0);
      chk(rd, 32'hfc00_0008); // masked bits read zero
      i_gab_host_model.set_size(6'h00);
      cfg(1'b1, 8'h14, 4'hf, 32'hffff_ffff);
      cfg(1'b0, 8'h14, 4'hf, 32'h0);
      chk(rd, 32'h0000_0000); // other offset reads zero
      cfg(1'b0, 8'h10, 4'hf, 32'h0);
      chk(rd, 32'hfc00_0008); // masked write stored zero
      cfg(1'b1, 8'h10, 4'h8, 32'h2000_0000);
      cfg(1'b1, 8'h10, 4'h3, 32'hffff_ffff);
      cfg(1'b0, 8'h10, 4'h0, 32'h0);
      chk(rd, 32'h2000_0008); // lanes 0 and 1 ignored
      // decode table, one access each with an idle gap
      for (k = 0; k < 6; k++)
      begin
         i_gab_host_model.set_size(t_m[k]);
         hcfg = t_en[k] ? 32'hffff_ffff : 32'hffff_fdff;
         cpu_go(t_we[k], t_a[k], t_be[k], 32'h5a5a_a5a5);
         chk({28'h0, rsp.route}, {28'h0, t_rt[k]}); // route
         chk({28'h0, rsp.be}, {28'h0, t_rb[k]}); // all bytes on translated reads
         chk(rsp.addr, t_a[k]); // address passed on
         chk({31'h0, rsp.we}, {31'h0, t_we[k]}); // direction passed on
         chk({31'h0, mwr_valid}, 32'h0); // no write emitted
         cpu.req = 1'b0;
      end
      // merge two writes to one dword, then flush by another dword and an idle cycle
      i_gab_host_model.set_size(6'h00);
      hcfg = 32'hffff_ffff;
      cpu_go(1'b1, 32'h2000_0106, 4'h1, 32'h0000_00aa);
      cpu_go(1'b1, 32'h2000_0104, 4'h2, 32'h0000_bb00);
      cpu_go(1'b1, 32'h2000_0200, 4'h8, 32'h1100_0000);
      chk({31'h0, mwr_valid}, 32'h1); // flushed by new dword
      chk(mwr_addr, 32'h2000_0104); // dword address
      chk({28'h0, mwr_be}, 32'h3); // enables combined
      chk(mwr_data & 32'h0000_ffff, 32'h0000_bbaa); // bytes combined
      cpu.req = 1'b0;
      @(posedge core_clk_in);
      #1;
      chk({31'h0, mwr_valid}, 32'h1); // flushed by idle cycle
      chk(mwr_addr, 32'h2000_0200); // second entry
      chk({28'h0, mwr_be}, 32'h8); // single enable kept
      chk(mwr_data & 32'hff00_0000, 32'h1100_0000); // data kept
      give_verdict();
   end
endmodule : tb
